//--- rtl/htiu_pkg.sv
package htiu_pkg;

  // Register byte offsets on the transmitter host register page
  localparam logic [7:0] HTIU_OFS_ENABLE = 8'h3c;
  localparam logic [7:0] HTIU_OFS_STATUS = 8'h3d;
  localparam logic [7:0] HTIU_OFS_STATUS2 = 8'h3e;
  localparam logic [7:0] HTIU_OFS_ENABLE2 = 8'h3f;

  // Reset values
  localparam logic [7:0] HTIU_RST_ENABLE = 8'h00;
  localparam logic [7:0] HTIU_RST_STATUS = 8'h00;
  localparam logic [7:0] HTIU_RST_STATUS2 = 8'h00;
  localparam logic [7:0] HTIU_RST_ENABLE2 = 8'h00;

  // Primary bit positions
  localparam int HTIU_B_ATTACH = 0;
  localparam int HTIU_B_RXDET = 1;
  localparam int HTIU_B_PINLVL = 2;
  localparam int HTIU_B_RXLVL = 3;
  localparam int HTIU_B_AUDIO = 4;
  localparam int HTIU_B_SEC = 5;
  localparam int HTIU_B_VREADY = 6;
  localparam int HTIU_B_AUTH = 7;

  // Secondary bit positions
  localparam int HTIU_B_LINK = 0;
  localparam int HTIU_B_KSV = 1;

  // Writable event and enable masks
  localparam logic [7:0] HTIU_EVT_MASK = 8'hf3;
  localparam logic [7:0] HTIU_EVT2_MASK = 8'h03;
  localparam logic [7:0] HTIU_EN_MASK = 8'hfb;
  localparam logic [7:0] HTIU_EN2_MASK = 8'h03;

  // Level-type observed sources
  typedef struct packed {
    logic sink_attach_signal;
    logic powered_receiver_detect;
    logic [1:0] link_status;
    logic [1:0] auth_status;
    logic vready;
    logic tmds_stable;
  } htiu_levels_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } htiu_req_t;

endpackage

//--- rtl/htiu_edge.sv
`timescale 1ns/1ps
`default_nettype none
module htiu_edge import htiu_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clock, // System clock
  input wire logic rstn, // Async reset, low
  input wire logic [W-1:0] level, // Observed levels
  output logic [W-1:0] prev, // Registered copy
  output logic [W-1:0] change // High when level differs
);

  typedef struct packed {
    logic primed;
    logic [W-1:0] prev;
  } htiu_edge_st_t;

  htiu_edge_st_t st_reg, st_next;

  // First cycle after reset only captures, so reset values raise no event
  always_comb begin
    st_next = st_reg;
    st_next.prev = level;
    st_next.primed = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prev = st_reg.prev;
  assign change = st_reg.primed ? (level ^ st_reg.prev) : '0;

endmodule
`default_nettype wire

//--- rtl/htiu_top.sv
`timescale 1ns/1ps
`default_nettype none
module htiu_top import htiu_pkg::*; (
  input wire logic clock, // 250 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic reg_wr, // Byte write strobe
  input wire logic reg_rd, // Byte read strobe
  input wire logic [7:0] reg_addr, // Byte offset
  input wire logic [7:0] reg_wdata, // Write byte
  output logic [7:0] reg_rdata, // Read byte, registered
  input wire logic sink_attach_signal, // Sink attach level
  input wire logic powered_receiver_detect, // Powered receiver level
  input wire logic remote_control_pending, // Remote page pending level
  input wire logic remote_control_irq, // Remote page own interrupt
  input wire logic spdif_event, // S/PDIF event handled pulse
  input wire logic audio_is_spdif, // Input path is S/PDIF
  input wire logic [1:0] link_status, // Link status field
  input wire logic [1:0] auth_status, // Authentication status field
  input wire logic vstar_selected, // A V* value is selected
  input wire logic vstar_ready, // V* ready status bit
  input wire logic tmds_stable, // TMDS clock stable level
  input wire logic ksv_first_byte, // First KSV byte received pulse
  input wire logic low_power, // Lowest power state
  output logic host_irq // Interrupt to host, high active
);

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] pend;
    logic [7:0] enable2;
    logic [7:0] pend2;
    logic [7:0] rdata;
  } htiu_st_t;

  htiu_st_t st_reg, st_next;
  htiu_req_t req;
  htiu_levels_t lv;
  logic [7:0] lv_vec, lv_prev, lv_chg;
  logic [7:0] set_evt, set_evt2, clr_evt, clr_evt2;
  logic [7:0] status_view;
  logic vready_rise;

  // Typed views of the change detector outputs
  htiu_levels_t lv_prev_s;
  htiu_levels_t lv_chg_s;

  // Decoded byte write strobes
  logic wr_enable;
  logic wr_status;
  logic wr_status2;
  logic wr_enable2;

  // Raw events and the low-power keep masks
  logic [7:0] raw_evt;
  logic [7:0] raw_evt2;
  logic [7:0] lp_keep;
  logic [7:0] lp_keep2;

  // Per-bit next values of flags and enables
  logic [7:0] pend_next;
  logic [7:0] pend2_next;
  logic [7:0] en_next;
  logic [7:0] en2_next;

  // Live status bits, read multiplexer and interrupt terms
  logic live_pin;
  logic live_rx;
  logic [7:0] rd_mux;
  logic [7:0] irq_terms;
  logic [7:0] irq_terms2;
  logic irq_local;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign lv = '{sink_attach_signal: sink_attach_signal,
                powered_receiver_detect: powered_receiver_detect,
                link_status: link_status, auth_status: auth_status,
                vready: vstar_ready, tmds_stable: tmds_stable};
  assign lv_vec = lv;

  // Change detection on every observed level
  htiu_edge #(.W(8)) u_edge (
    .clock(clock),
    .rstn(rstn),
    .level(lv_vec),
    .prev(lv_prev),
    .change(lv_chg)
  );

  // Typed views of the detector outputs
  assign lv_prev_s = lv_prev;
  assign lv_chg_s = lv_chg;

  // V* ready event on the rising edge while a value is selected
  assign vready_rise = vstar_selected && vstar_ready && !lv_prev_s.vready;

  // Byte write strobes shared by the clear and the update logic
  assign wr_enable = req.wr && (req.addr == HTIU_OFS_ENABLE);
  assign wr_status = req.wr && (req.addr == HTIU_OFS_STATUS);
  assign wr_status2 = req.wr && (req.addr == HTIU_OFS_STATUS2);
  assign wr_enable2 = req.wr && (req.addr == HTIU_OFS_ENABLE2);

  // Raw event sources, one bit per pending flag position
  always_comb begin
    raw_evt = 8'h00;
    raw_evt2 = 8'h00;
    raw_evt[HTIU_B_ATTACH] = lv_chg_s.sink_attach_signal;
    raw_evt[HTIU_B_RXDET] = lv_chg_s.powered_receiver_detect;
    raw_evt[HTIU_B_AUDIO] = spdif_event && audio_is_spdif;
    raw_evt[HTIU_B_SEC] = |lv_chg_s.link_status;
    raw_evt[HTIU_B_VREADY] = vready_rise;
    raw_evt[HTIU_B_AUTH] = |lv_chg_s.auth_status;
    raw_evt2[HTIU_B_LINK] = lv_chg_s.tmds_stable && tmds_stable;
    raw_evt2[HTIU_B_KSV] = ksv_first_byte;
  end

  // Lowest power state suspends every event but sink attach
  always_comb begin
    lp_keep = low_power ? 8'h00 : 8'hff;
    lp_keep2 = low_power ? 8'h00 : 8'hff;
    lp_keep[HTIU_B_ATTACH] = 1'b1;
  end

  // Events that reach the pending flags
  assign set_evt = raw_evt & lp_keep;
  assign set_evt2 = raw_evt2 & lp_keep2;

  // Clear requests from host byte writes; live bits 3:2 are masked out
  always_comb begin
    clr_evt = 8'h00;
    clr_evt2 = 8'h00;
    if (wr_enable) begin
      clr_evt = req.wdata & HTIU_EVT_MASK;
    end
    if (wr_status) begin
      clr_evt = req.wdata & HTIU_EVT_MASK;
    end
    if (wr_status2) begin
      clr_evt2 = req.wdata & HTIU_EVT2_MASK;
    end
    if (wr_enable2) begin
      clr_evt2 = req.wdata & HTIU_EVT2_MASK;
    end
  end

  // Per-bit next values; set beats clear, bits outside the masks stay zero
  for (genvar gi = 0; gi < 8; gi++) begin : g_bit
    if (HTIU_EVT_MASK[gi]) begin : g_pend
      assign pend_next[gi] = set_evt[gi] || (st_reg.pend[gi] && !clr_evt[gi]);
    end else begin : g_pend_none
      assign pend_next[gi] = 1'b0;
    end
    if (HTIU_EVT2_MASK[gi]) begin : g_pend2
      assign pend2_next[gi] = set_evt2[gi] || (st_reg.pend2[gi] && !clr_evt2[gi]);
    end else begin : g_pend2_none
      assign pend2_next[gi] = 1'b0;
    end
    if (HTIU_EN_MASK[gi]) begin : g_en
      assign en_next[gi] = wr_enable ? req.wdata[gi] : st_reg.enable[gi];
    end else begin : g_en_rsvd
      assign en_next[gi] = 1'b0;
    end
    if (HTIU_EN2_MASK[gi]) begin : g_en2
      assign en2_next[gi] = wr_enable2 ? req.wdata[gi] : st_reg.enable2[gi];
    end else begin : g_en2_rsvd
      assign en2_next[gi] = 1'b0;
    end
  end

  // Live state at bits 2 and 3; bit 3 follows the remote page when mirrored
  assign live_pin = sink_attach_signal;
  assign live_rx = st_reg.enable[HTIU_B_RXLVL] ? remote_control_pending : powered_receiver_detect;

  // Status byte as the host sees it
  always_comb begin
    status_view = st_reg.pend & HTIU_EVT_MASK;
    status_view[HTIU_B_PINLVL] = live_pin;
    status_view[HTIU_B_RXLVL] = live_rx;
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    unique case (req.addr)
      HTIU_OFS_ENABLE: rd_mux = st_reg.enable;
      HTIU_OFS_STATUS: rd_mux = status_view;
      HTIU_OFS_STATUS2: rd_mux = st_reg.pend2;
      HTIU_OFS_ENABLE2: rd_mux = st_reg.enable2;
      default: rd_mux = 8'h00;
    endcase
  end

  // Register update; the read byte is captured only on a read
  always_comb begin
    st_next = st_reg;
    st_next.pend = pend_next;
    st_next.pend2 = pend2_next;
    st_next.enable = en_next;
    st_next.enable2 = en2_next;
    if (req.rd) begin
      st_next.rdata = rd_mux;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg.enable <= HTIU_RST_ENABLE;
      st_reg.pend <= HTIU_RST_STATUS;
      st_reg.enable2 <= HTIU_RST_ENABLE2;
      st_reg.pend2 <= HTIU_RST_STATUS2;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;

  // Enabled pending flags, primary and secondary
  assign irq_terms = st_reg.pend & st_reg.enable & HTIU_EVT_MASK;
  assign irq_terms2 = st_reg.pend2 & st_reg.enable2;
  assign irq_local = |{irq_terms, irq_terms2};

  // Remote-control interrupt is passed on whatever enable bit 3 says
  assign host_irq = irq_local || remote_control_irq;

endmodule
`default_nettype wire

//--- sim/htiu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module htiu_monitor import htiu_pkg::*; (
  input wire logic clock, // Clock
  input wire logic rstn, // Reset, low
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [7:0] reg_wdata, // Write byte
  input wire logic [7:0] reg_rdata, // Read byte
  input wire logic sink_attach_signal, // Attach level
  input wire logic remote_control_irq, // Remote interrupt
  input wire logic host_irq // Host interrupt
);
  logic [7:0] en_q;
  logic [7:0] en2_q;
  logic [1:0] age;
  // Shadow enables and count cycles since reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_q <= 8'h00;
      en2_q <= 8'h00;
      age <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == HTIU_OFS_ENABLE) en_q <= reg_wdata & HTIU_EN_MASK;
      if (reg_wr && reg_addr == HTIU_OFS_ENABLE2) en2_q <= reg_wdata & HTIU_EN2_MASK;
      if (age != 2'h3) age <= age + 2'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Register path
  AST_RD_UNMAPPED: assert property (reg_rd && (reg_addr < 8'h3c || reg_addr > 8'h3f) |=> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("Read byte moved without a read");
  AST_EN_RSVD: assert property (reg_rd && reg_addr == HTIU_OFS_ENABLE |=> !reg_rdata[2])
    else $error("Reserved enable bit reads one");
  AST_SEC_RSVD: assert property (reg_rd && reg_addr inside {8'h3e, 8'h3f} |=> reg_rdata[7:2] == 6'h00)
    else $error("Secondary reserved bits nonzero");
  AST_PIN_LIVE: assert property (reg_rd && reg_addr == HTIU_OFS_STATUS && $stable(sink_attach_signal) |=>
    reg_rdata[2] == $past(sink_attach_signal)) else $error("Attach pin level not live");
  // Interrupt output
  AST_REMOTE_IRQ: assert property (remote_control_irq |-> host_irq)
    else $error("Remote interrupt not passed on");
  AST_ATTACH_EVT: assert property (age == 2'h3 && $changed(sink_attach_signal) && en_q[0] &&
    !(reg_wr && reg_addr == HTIU_OFS_ENABLE && !reg_wdata[0]) |-> ##[1:2] host_irq)
    else $error("Attach change raised no interrupt");
  AST_IRQ_MASKED: assert property (en_q == 8'h00 && en2_q == 8'h00 |-> host_irq == remote_control_irq)
    else $error("Interrupt with all sources disabled");
endmodule
bind htiu_top htiu_monitor u_htiu_monitor (.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sink_attach_signal(sink_attach_signal),
  .remote_control_irq(remote_control_irq), .host_irq(host_irq));
`default_nettype wire

//--- sim/htiu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module htiu_host_model (
  input wire logic clock, // Clock
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_addr, // Offset
  output logic [7:0] reg_wdata, // Write byte
  input wire logic [7:0] reg_rdata // Read byte
);
  // Bus idle at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Single byte write, released data inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // Single byte read, data taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- sim/hdmi_tx_interrupt_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hdmi_tx_interrupt_unit_tb_top;
  logic clock, rstn, reg_wr, reg_rd, sink_attach_signal, powered_receiver_detect, remote_control_pending;
  logic remote_control_irq, spdif_event, audio_is_spdif, vstar_selected, vstar_ready, tmds_stable;
  logic ksv_first_byte, low_power, host_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0] link_status, auth_status;
  int err_total, cmp_count;
  htiu_top u_htiu_top (.clock, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sink_attach_signal,
    .powered_receiver_detect, .remote_control_pending, .remote_control_irq, .spdif_event, .audio_is_spdif,
    .link_status, .auth_status, .vstar_selected, .vstar_ready, .tmds_stable, .ksv_first_byte, .low_power, .host_irq);
  htiu_host_model u_htiu_host_model (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  // Compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_htiu_host_model.rd(a, rv);
    chk("reg_rdata", rv, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_htiu_host_model.wr(a, d);
  endtask
  task automatic tk;
    repeat (3) @(negedge clock);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Attach event, clear by one, pin level stays
  task automatic t_attach;
    wr(8'h3c, 8'h01);
    sink_attach_signal = 1'b1;
    tk;
    rc(8'h3d, 8'h05);
    chk("host_irq", 8'(host_irq), 8'h01);
    wr(8'h3d, 8'hff);
    rc(8'h3d, 8'h04);
    chk("host_irq", 8'(host_irq), 8'h00);
  endtask
  // Receiver detect, disabled latch, enable write clears or keeps
  task automatic t_rx;
    wr(8'h3c, 8'h00);
    powered_receiver_detect = 1'b1;
    tk;
    rc(8'h3d, 8'h0e);
    wr(8'h3c, 8'h02);
    rc(8'h3d, 8'h0c);
    powered_receiver_detect = 1'b0;
    tk;
    chk("host_irq", 8'(host_irq), 8'h01);
    wr(8'h3c, 8'h00);
    rc(8'h3d, 8'h06);
    wr(8'h3d, 8'hff);
  endtask
  // Remote page mirror and its own interrupt
  task automatic t_mirror;
    wr(8'h3c, 8'h08);
    remote_control_pending = 1'b1;
    tk;
    rc(8'h3d, 8'h0c);
    wr(8'h3d, 8'h08);
    rc(8'h3d, 8'h0c);
    wr(8'h3c, 8'h00);
    remote_control_irq = 1'b1;
    tk;
    chk("host_irq", 8'(host_irq), 8'h01);
    remote_control_irq = 1'b0;
    remote_control_pending = 1'b0;
  endtask
  // Audio, security, V* and authentication events
  task automatic t_events;
    wr(8'h3c, 8'hf0);
    {spdif_event, vstar_ready} = 2'h3;
    @(negedge clock) spdif_event = 1'b0;
    tk;
    rc(8'h3d, 8'h04);
    {spdif_event, audio_is_spdif, link_status, auth_status, vstar_selected} = 7'h6b;
    vstar_ready = 1'b0;
    @(negedge clock) spdif_event = 1'b0;
    vstar_ready = 1'b1;
    tk;
    rc(8'h3d, 8'hf4);
    wr(8'h3d, 8'hf0);
    rc(8'h3d, 8'h04);
  endtask
  // Secondary flags and low power
  task automatic t_sec;
    wr(8'h3f, 8'h03);
    tmds_stable = 1'b1;
    ksv_first_byte = 1'b1;
    @(negedge clock) ksv_first_byte = 1'b0;
    tk;
    rc(8'h3e, 8'h03);
    wr(8'h3e, 8'h01);
    rc(8'h3e, 8'h02);
    wr(8'h3e, 8'h02);
    wr(8'h3f, 8'h00);
    low_power = 1'b1;
    sink_attach_signal = 1'b0;
    link_status = 2'h2;
    tk;
    rc(8'h3d, 8'h01);
  endtask
  // Reset values of every register and one unmapped offset
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rc(8'h3c + 8'(i % 5), 8'h00);
  endtask
  // Reserved and unmapped bits refuse writes
  task automatic t_masks;
    wr(8'h3c, 8'hff);
    wr(8'h3f, 8'hff);
    wr(8'h3e, 8'hff);
    wr(8'h40, 8'h00);
    rc(8'h3c, 8'hfb);
    rc(8'h3f, 8'h03);
    rc(8'h3e, 8'h00);
    rc(8'h40, 8'h00);
    chk("host_irq", 8'(host_irq), 8'h00);
    wr(8'h3c, 8'h00);
    wr(8'h3f, 8'h00);
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #20000;
    err_total++;
    wrap_up;
  end
  initial begin
    {rstn, sink_attach_signal, powered_receiver_detect, remote_control_pending, remote_control_irq} = 5'h0;
    {spdif_event, audio_is_spdif, vstar_selected, vstar_ready, tmds_stable, ksv_first_byte, low_power} = 7'h0;
    {link_status, auth_status} = 4'h0;
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    t_reset;
    t_masks;
    t_attach;
    t_rx;
    t_mirror;
    t_events;
    t_sec;
    wrap_up;
  end
endmodule
`default_nettype wire
